//--- pfc_pin_model.sv
// far-side pins: external drivers, on-chip pull-ups, floating lines
`timescale 1ns/1ps
`default_nettype none
module pfc_pin_model
  import pfc_pkg::*;
(
  input  wire logic          core_clk,
  input  wire pfc_port_vec_t pin_out,
  input  wire pfc_port_vec_t pin_oe,
  input  wire pfc_port_vec_t pullup_en,
  input  wire pfc_port_vec_t ext_drv,
  input  wire pfc_port_vec_t ext_en,
  output var  pfc_port_vec_t pin_in
);
  logic tog_q = 1'b0;
  // a floating line toggles each cycle, so the agreement filter never takes it and its last settled level keeps reading
  always @(posedge core_clk) tog_q <= !tog_q;
  always_comb pin_in = (pin_out & pin_oe)
    | (~pin_oe & ext_en & ext_drv)
    | (~pin_oe & ~ext_en & (pullup_en | {24{tog_q}}));
endmodule // pfc_pin_model
`default_nettype wire

//--- pfc_pkg.sv
// package for the port function control block
package pfc_pkg;
  localparam logic [15:0] PFC_ADDR_P2_DATA   = 16'hff02;
  localparam logic [15:0] PFC_ADDR_P3_DATA   = 16'hff03;
  localparam logic [15:0] PFC_ADDR_P4_DATA   = 16'hff04;
  localparam logic [15:0] PFC_ADDR_P2_DIR    = 16'hff22;
  localparam logic [15:0] PFC_ADDR_P3_DIR    = 16'hff23;
  localparam logic [15:0] PFC_ADDR_P4_DIR    = 16'hff24;
  localparam logic [15:0] PFC_ADDR_P2_PULLUP = 16'hff32;
  localparam logic [15:0] PFC_ADDR_P3_PULLUP = 16'hff33;
  localparam logic [15:0] PFC_ADDR_P4_PULLUP = 16'hff34;
  localparam logic [15:0] PFC_ADDR_P2_ANSEL  = 16'hff84;

  localparam logic [7:0] PFC_DIR_RESET    = 8'hff;
  localparam logic [7:0] PFC_DATA_RESET   = 8'h00;
  localparam logic [7:0] PFC_ANSEL_RESET  = 8'h00;
  localparam logic [7:0] PFC_PULLUP_RESET = 8'h00;

  // implemented bit masks of each port
  localparam logic [7:0] PFC_P2_MASK      = 8'h0f;
  localparam logic [7:0] PFC_P3_MASK      = 8'h04;
  localparam logic [7:0] PFC_P4_MASK      = 8'hff;
  localparam int         PFC_P3_IO_BIT    = 2;
  localparam int         PFC_P3_IN_BIT    = 4;
  localparam int         PFC_P2_IRQ_BIT   = 1;
  localparam int         PFC_SYNC_STAGES  = 3;

  typedef struct packed {
    logic       wr;
    logic       bit_op;
    logic [2:0] bit_sel;
    logic [15:0] addr;
    logic [7:0] wdata;
  } pfc_bus_req_t;

  typedef struct packed {
    logic [7:0] p2;
    logic [7:0] p3;
    logic [7:0] p4;
  } pfc_port_vec_t;
endpackage : pfc_pkg

//--- pfc_port_ctrl.sv
// port function control: direction, data, analog select, pull-up, pin drive
`timescale 1ns/1ps
`default_nettype none
module pfc_port_ctrl
  import pfc_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire pfc_bus_req_t  bus_req,
  input  wire logic          bus_rd,
  input  wire pfc_port_vec_t pin_in,
  output var  logic [7:0]    bus_rdata,
  output var  pfc_port_vec_t pin_out,
  output var  pfc_port_vec_t pin_oe,
  output var  pfc_port_vec_t pullup_en,
  output var  logic [3:0]    analog_sel,
  output var  logic          irq_req_zero,
  output var  logic          irq_req_one
);
  localparam int NREG = 10;

  function automatic logic [NREG-1:0] pfc_decode(input logic [15:0] addr);
    logic [NREG-1:0] hit;
    hit    = '0;
    hit[0] = (addr == PFC_ADDR_P2_DATA);
    hit[1] = (addr == PFC_ADDR_P3_DATA);
    hit[2] = (addr == PFC_ADDR_P4_DATA);
    hit[3] = (addr == PFC_ADDR_P2_DIR);
    hit[4] = (addr == PFC_ADDR_P3_DIR);
    hit[5] = (addr == PFC_ADDR_P4_DIR);
    hit[6] = (addr == PFC_ADDR_P2_PULLUP);
    hit[7] = (addr == PFC_ADDR_P3_PULLUP);
    hit[8] = (addr == PFC_ADDR_P4_PULLUP);
    hit[9] = (addr == PFC_ADDR_P2_ANSEL);
    return hit;
  endfunction

  localparam logic [NREG*8-1:0] RST_VALS = {PFC_ANSEL_RESET, PFC_PULLUP_RESET,
    PFC_PULLUP_RESET, PFC_PULLUP_RESET, PFC_DIR_RESET, PFC_DIR_RESET, PFC_DIR_RESET,
    PFC_DATA_RESET, PFC_DATA_RESET, PFC_DATA_RESET};
  localparam logic [NREG*8-1:0] MASKS = {PFC_P2_MASK, PFC_P4_MASK, PFC_P3_MASK,
    PFC_P2_MASK, PFC_P4_MASK, PFC_P3_MASK, PFC_P2_MASK, PFC_P4_MASK, PFC_P3_MASK,
    PFC_P2_MASK};
  // direction registers fill unimplemented bits with ones, others with zeros
  localparam logic [NREG*8-1:0] FILLS = {8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
    8'hff, 8'h00, 8'h00, 8'h00};

  logic [NREG-1:0] wr_hit;
  logic [7:0]      regs [NREG];

  assign wr_hit = bus_req.wr ? pfc_decode(bus_req.addr) : '0;

  generate
    for (genvar g = 0; g < NREG; g++) begin : g_reg
      pfc_reg8 #(
        .RESET_VAL (RST_VALS[g*8 +: 8]),
        .IMPL_MASK (MASKS[g*8 +: 8]),
        .FILL_VAL  (FILLS[g*8 +: 8])
      ) u_reg (
        .core_clk (core_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .wr_en    (wr_hit[g]),
        .bit_op   (bus_req.bit_op),
        .bit_sel  (bus_req.bit_sel),
        .wdata    (bus_req.wdata),
        .value    (regs[g])
      );
    end
  endgenerate

  pfc_port_vec_t pin_sync;
  logic [23:0]   pin_sync_flat;

  pfc_sync #(
    .WIDTH (24)
  ) u_sync (
    .core_clk  (core_clk),
    .rst       (rst),
    .clk_en    (clk_en),
    .pin_async (pin_in),
    .pin_sync  (pin_sync_flat)
  );
  assign pin_sync = pin_sync_flat;

  typedef struct packed {
    logic [7:0]    rdata;
    pfc_port_vec_t out;
    pfc_port_vec_t oe;
    pfc_port_vec_t pull;
    logic [3:0]    ansel;
    logic          irq0;
    logic          irq1;
  } pfc_state_t;

  pfc_state_t state_q;
  pfc_state_t state_d;
  logic [7:0] dir2;
  logic [7:0] dir3;
  logic [7:0] dir4;
  logic [7:0] an2;
  logic [7:0] rd_p2;
  logic [7:0] rd_p3;
  logic [7:0] rd_p4;
  logic [NREG-1:0] rd_hit;

  assign dir2 = regs[3];
  assign dir3 = regs[4];
  assign dir4 = regs[5];
  assign an2  = {4'h0, regs[9][3:0]};

  always_comb begin
    // read mux: pin level in input mode, latch in output mode
    rd_p2 = ((dir2 & pin_sync.p2) | (~dir2 & regs[0])) & PFC_P2_MASK;
    rd_p2 = rd_p2 & ~an2;
    rd_p3 = ((dir3 & pin_sync.p3) | (~dir3 & regs[1])) & PFC_P3_MASK;
    rd_p3[PFC_P3_IN_BIT] = pin_sync.p3[PFC_P3_IN_BIT];
    rd_p4 = (dir4 & pin_sync.p4) | (~dir4 & regs[2]);
    rd_hit = bus_rd ? pfc_decode(bus_req.addr) : '0;

    state_d       = state_q;
    state_d.rdata = 8'h00;
    unique case (1'b1)
      rd_hit[0]: state_d.rdata = rd_p2;
      rd_hit[1]: state_d.rdata = rd_p3;
      rd_hit[2]: state_d.rdata = rd_p4;
      rd_hit[3]: state_d.rdata = dir2;
      rd_hit[4]: state_d.rdata = dir3;
      rd_hit[5]: state_d.rdata = dir4;
      rd_hit[6]: state_d.rdata = regs[6];
      rd_hit[7]: state_d.rdata = regs[7];
      rd_hit[8]: state_d.rdata = regs[8];
      rd_hit[9]: state_d.rdata = regs[9];
      default:   state_d.rdata = 8'h00;
    endcase

    // drivers: enabled only for output mode, digital use
    state_d.out.p2 = regs[0] & PFC_P2_MASK;
    state_d.out.p3 = regs[1] & PFC_P3_MASK;
    state_d.out.p4 = regs[2];
    state_d.oe.p2  = ~dir2 & ~an2 & PFC_P2_MASK;
    state_d.oe.p3  = ~dir3 & PFC_P3_MASK;
    state_d.oe.p4  = ~dir4;
    state_d.pull.p2 = regs[6] & PFC_P2_MASK & dir2 & ~an2;
    state_d.pull.p3 = regs[7] & PFC_P3_MASK & dir3;
    state_d.pull.p4 = regs[8] & dir4;
    state_d.ansel   = regs[9][3:0];

    // interrupt-shared pins see their own driven level, so a change while
    // driving looks like an edge; one-cycle request pulses
    state_d.irq0 = state_d.oe.p2[PFC_P2_IRQ_BIT] && state_q.oe.p2[PFC_P2_IRQ_BIT]
      && (state_d.out.p2[PFC_P2_IRQ_BIT] != state_q.out.p2[PFC_P2_IRQ_BIT]);
    state_d.irq1 = state_d.oe.p3[PFC_P3_IO_BIT] && state_q.oe.p3[PFC_P3_IO_BIT]
      && (state_d.out.p3[PFC_P3_IO_BIT] != state_q.out.p3[PFC_P3_IO_BIT]);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  assign bus_rdata    = state_q.rdata;
  assign pin_out      = state_q.out;
  assign pin_oe       = state_q.oe;
  assign pullup_en    = state_q.pull;
  assign analog_sel   = state_q.ansel;
  assign irq_req_zero = state_q.irq0;
  assign irq_req_one  = state_q.irq1;
endmodule // pfc_port_ctrl
`default_nettype wire

//--- pfc_properties.sv
// assertions on the port function control ports
`timescale 1ns/1ps
`default_nettype none
module pfc_chk
  import pfc_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          rst,
  input wire logic          clk_en,
  input wire pfc_bus_req_t  bus_req,
  input wire logic          bus_rd,
  input wire logic [7:0]    bus_rdata,
  input wire pfc_port_vec_t pin_out,
  input wire pfc_port_vec_t pin_oe,
  input wire pfc_port_vec_t pullup_en,
  input wire logic [3:0]    analog_sel,
  input wire logic          irq_req_zero,
  input wire logic          irq_req_one
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence rd_at(logic [15:0] a);
    clk_en && bus_rd && bus_req.addr == a;
  endsequence
  sequence wr_at(logic [15:0] a);
    clk_en && bus_req.wr && !bus_req.bit_op && bus_req.addr == a;
  endsequence
  // three quiet cycles let one write reach the pins with nothing behind it
  sequence settle;
    (clk_en && !bus_req.wr) [*3];
  endsequence
  a_reset_all_input: assert property (disable iff (1'b0)
    rst && clk_en |=> pin_oe == '0 && analog_sel == 4'h0)
    else $error("pins active in reset");
  a_p2_data_zero: assert property (rd_at(PFC_ADDR_P2_DATA) |=> bus_rdata[7:4] == 4'h0)
    else $error("port two data upper bits set");
  a_p2_dir_fill: assert property (rd_at(PFC_ADDR_P2_DIR) |=> bus_rdata[7:4] == 4'hf)
    else $error("port two direction upper bits clear");
  a_p3_dir_fill: assert property (rd_at(PFC_ADDR_P3_DIR) |=> (bus_rdata | 8'h04) == 8'hff)
    else $error("port three direction fixed bits clear");
  a_analog_no_drive: assert property ((pin_oe.p2[3:0] & analog_sel) == 4'h0)
    else $error("analog pin driven");
  a_pullup_off_drive: assert property ((pullup_en & pin_oe) == '0)
    else $error("pull-up on a driven pin");
  a_dir_to_drive: assert property (wr_at(PFC_ADDR_P4_DIR) ##1 settle
    |-> pin_oe.p4 == ~$past(bus_req.wdata, 3))
    else $error("driver enable differs from direction");
  a_latch_to_pin: assert property (wr_at(PFC_ADDR_P4_DATA) ##1 settle
    |-> (pin_out.p4 & pin_oe.p4) == ($past(bus_req.wdata, 3) & pin_oe.p4))
    else $error("pin level differs from latch");
  a_irq_on_toggle: assert property (wr_at(PFC_ADDR_P2_DATA)
    ##0 (pin_oe.p2[1] && bus_req.wdata[1] != pin_out.p2[1]) |-> ##[1:4] irq_req_zero)
    else $error("no request on shared pin toggle");
  a_irq_one_toggle: assert property (wr_at(PFC_ADDR_P3_DATA)
    ##0 (pin_oe.p3[2] && bus_req.wdata[2] != pin_out.p3[2]) |-> ##[1:4] irq_req_one)
    else $error("no request on port three shared pin toggle");
endmodule // pfc_chk
bind pfc_port_ctrl pfc_chk u_chk (.core_clk, .rst, .clk_en, .bus_req, .bus_rd,
  .bus_rdata, .pin_out, .pin_oe, .pullup_en, .analog_sel, .irq_req_zero, .irq_req_one);
`default_nettype wire

//--- pfc_reg8.sv
// one 8-bit port control register with bit and byte writes
`timescale 1ns/1ps
`default_nettype none
module pfc_reg8
  import pfc_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] IMPL_MASK = 8'hff,
  parameter logic [7:0] FILL_VAL  = 8'h00
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic       wr_en,
  input  wire logic       bit_op,
  input  wire logic [2:0] bit_sel,
  input  wire logic [7:0] wdata,
  output var  logic [7:0] value
);
  logic [7:0] reg_q;
  logic [7:0] reg_d;

  always_comb begin
    reg_d = reg_q;
    if (wr_en) begin
      if (bit_op) begin
        reg_d[bit_sel] = wdata[0];
      end else begin
        reg_d = wdata;
      end
    end
    // unimplemented bits keep their fixed value
    reg_d = (reg_d & IMPL_MASK) | (FILL_VAL & ~IMPL_MASK);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_q <= RESET_VAL;
    end else if (clk_en) begin
      reg_q <= reg_d;
    end
  end

  assign value = reg_q;
endmodule // pfc_reg8
`default_nettype wire

//--- pfc_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pfc_sync
  import pfc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] pin_async,
  output var  logic [WIDTH-1:0] pin_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } pfc_sync_state_t;

  pfc_sync_state_t state_q;
  pfc_sync_state_t state_d;

  always_comb begin
    state_d    = state_q;
    state_d.s1 = pin_async;
    state_d.s2 = state_q.s1;
    state_d.s3 = state_q.s2;
    // a change counts only once stages two and three agree
    for (int i = 0; i < WIDTH; i++) begin
      if (state_q.s2[i] == state_q.s3[i]) begin
        state_d.held[i] = state_q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  assign pin_sync = state_q.held;
endmodule // pfc_sync
`default_nettype wire

//--- pfc_tb.sv
// self-checking bench for the port function control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module testbench;
  import pfc_pkg::*;
  logic          core_clk = 0, rst = 1, bus_rd = 0, clk_en = 1, irq0, irq1;
  int            irq0_cnt = 0, irq1_cnt = 0;
  pfc_bus_req_t  req = '0;
  pfc_port_vec_t pin_in, pin_out, pin_oe, pull, drv = '0, den = '1;
  logic [7:0]    rdata;
  logic [3:0]    ansel;
  int            fails = 0, checks_done = 0, cyc = 0;
  logic [15:0]   ra[6] = '{PFC_ADDR_P2_DIR, PFC_ADDR_P3_DIR, PFC_ADDR_P4_DIR,
                           PFC_ADDR_P2_ANSEL, PFC_ADDR_P4_PULLUP, PFC_ADDR_P2_DATA};
  logic [7:0]    rv[6] = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
  always #2.5 core_clk = !core_clk;
  pfc_port_ctrl DUT (.core_clk, .rst, .clk_en, .bus_req(req), .bus_rd, .pin_in,
    .bus_rdata(rdata), .pin_out, .pin_oe, .pullup_en(pull), .analog_sel(ansel),
    .irq_req_zero(irq0), .irq_req_one(irq1));
  // request pulses stand one cycle, so they are counted at every edge
  always @(posedge core_clk) begin
    if (irq0 === 1'b1) irq0_cnt <= irq0_cnt + 1;
    if (irq1 === 1'b1) irq1_cnt <= irq1_cnt + 1;
  end
  pfc_pin_model ext (.core_clk, .pin_out, .pin_oe, .pullup_en(pull), .ext_drv(drv),
    .ext_en(den), .pin_in);
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b = 0,
                    input logic [2:0] s = 0);
    req <= '{1'b1, b, s, a, d};
    @(posedge core_clk) req.wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    req.addr <= a;
    bus_rd   <= 1'b1;
    @(posedge core_clk) bus_rd <= 1'b0;
    #1 `CHK(rdata, e)
    @(posedge core_clk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic end_of_test;
    $display("checks_done %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ceiling well above the hundred or so cycles the sequence needs
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(16'hff10, 8'h5a);
    rd(16'hff10, 8'h00);
    drv <= '1;
    wr(PFC_ADDR_P4_DIR, 8'h00);
    idle(2);
    rd(PFC_ADDR_P4_DATA, 8'h00);
    wr(PFC_ADDR_P4_DIR, 8'h0f);
    drv.p4 <= 8'h3c;
    wr(PFC_ADDR_P4_DATA, 8'ha5);
    idle(6);
    rd(PFC_ADDR_P4_DATA, 8'hac);
    `CHK(pin_oe.p4, 8'hf0)
    `CHK(pin_out.p4 & 8'hf0, 8'ha0)
    wr(PFC_ADDR_P4_DATA, 8'h00, 1, 3'd5);
    wr(PFC_ADDR_P4_DIR, 8'h00, 1, 3'd0);
    idle(6);
    rd(PFC_ADDR_P4_DATA, 8'h8d);
    den.p4 <= 8'h00;
    wr(PFC_ADDR_P4_PULLUP, 8'hff);
    idle(6);
    `CHK(pull.p4, 8'h0e)
    rd(PFC_ADDR_P4_DATA, 8'h8f);
    wr(PFC_ADDR_P2_DIR, 8'h00);
    rd(PFC_ADDR_P2_DIR, 8'hf0);
    wr(PFC_ADDR_P3_DIR, 8'h00);
    rd(PFC_ADDR_P3_DIR, 8'hfb);
    wr(PFC_ADDR_P2_DATA, 8'hff);
    rd(PFC_ADDR_P2_DATA, 8'h0f);
    wr(PFC_ADDR_P2_ANSEL, 8'h01, 1, 3'd2);
    wr(PFC_ADDR_P2_ANSEL, 8'h01, 1, 3'd0);
    idle(2);
    `CHK(ansel, 4'h5)
    `CHK(pin_oe.p2, 8'h0a)
    rd(PFC_ADDR_P2_ANSEL, 8'h05);
    rd(PFC_ADDR_P2_DATA, 8'h0a);
    wr(PFC_ADDR_P2_DIR, 8'h01, 1, 3'd0);
    wr(PFC_ADDR_P2_DIR, 8'h01, 1, 3'd2);
    `CHK(pin_oe.p2, 8'h0a)
    wr(PFC_ADDR_P2_DATA, 8'h0d);
    drv.p3 <= 8'h00;
    wr(PFC_ADDR_P3_DATA, 8'hff);
    idle(6);
    rd(PFC_ADDR_P3_DATA, 8'h04);
    drv.p3 <= 8'h10;
    idle(6);
    rd(PFC_ADDR_P3_DATA, 8'h14);
    clk_en <= 1'b0;
    wr(PFC_ADDR_P4_DATA, 8'h00);
    clk_en <= 1'b1;
    idle(2);
    rd(PFC_ADDR_P4_DATA, 8'h8f);
    `CHK(irq0_cnt, 2)
    `CHK(irq1_cnt, 1)
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
